// ### core/tsi_pkg.sv
// Summary of operation
// - two internal timing buses each carry clock, sync and gate to converter paths.
// - external clock goes straight or divided to converter sections, giving different clocks.
// - vcxo mode uses on-board oscillator; front-panel input becomes 10 MHz lock reference.
// - as sync-bus slave, take clock, sync and gate from the bus inputs.
// - as sync-bus master, drive clock, sync and gate onto the shared bus.
// - host link supports up to eight lanes and runs at reduced width automatically.
// - link indicator blinks once the host link is up.
// - master indicator lit while bus master, dark otherwise.
// - pps indicator lit while pulses valid, blinking at the pulse rate.
// - thermal indicator lit when any sensor reports over-temperature or over-voltage.
// - clock indicator lit only with valid clock; no data processed without one.
// - per-input overload indicator on analog overload or capture fifo overrun.
// - user indicator driven only by the user application.
// - dividers by 1, 2, 4, 8 or 16, set separately for input and output clocks.
// - clock source selectable among vcxo, external clock and timing bus.
package tsi_pkg;

  typedef enum logic [1:0] {
    TSI_SRC_VCXO = 2'b00,
    TSI_SRC_EXT  = 2'b01,
    TSI_SRC_BUS  = 2'b10
  } tsi_src_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_KHZ = 125000;
  localparam int unsigned REF_CLK_MHZ = 10;
  localparam int unsigned LINK_BLINK_MS = 250;
  localparam int unsigned LINK_BLINK_CYC = LINK_BLINK_MS * SYS_CLK_KHZ;
  localparam int unsigned PPS_TIMEOUT_MS = 1500;
  localparam int unsigned PPS_TIMEOUT_CYC = PPS_TIMEOUT_MS * SYS_CLK_KHZ;
  localparam int unsigned PPS_ON_MS = 100;
  localparam int unsigned PPS_ON_CYC = PPS_ON_MS * SYS_CLK_KHZ;
  localparam int unsigned CLKDET_WIN_CYC = 1024;

  // ----------------------------------------------------------------
  // reset values and field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;
  localparam logic [3:0] LINK_WIDTH_RST = 4'h0;
  localparam logic [15:0] EDGE_CNT_RST = 16'h0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam int unsigned SYNC_STAGES = 3;

  // half period, minus one, in source edges for a divider code
  function automatic logic [3:0] tsi_half(input logic [2:0] code);
    case (code)
      3'h0: tsi_half = 4'h0;
      3'h1: tsi_half = 4'h0;
      3'h2: tsi_half = 4'h1;
      3'h3: tsi_half = 4'h3;
      default: tsi_half = 4'h7;
    endcase
  endfunction : tsi_half

endpackage : tsi_pkg

// ### core/tsi_timing_status.sv
`timescale 1ns/100ps
module tsi_timing_status
  import tsi_pkg::*;
#(
  parameter int unsigned NSENS = 4,
  parameter int unsigned NCH = 3,
  parameter int unsigned LINK_BLINK = LINK_BLINK_CYC,
  parameter int unsigned PPS_TIMEOUT = PPS_TIMEOUT_CYC,
  parameter int unsigned PPS_ON = PPS_ON_CYC
) (
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [1:0] clk_src_sel, // vcxo, external or bus source
  input wire logic vcxo_ref_en, // external input used as vcxo reference
  input wire logic [2:0] adc_div_code, // input clock divider code
  input wire logic [2:0] dac_div_code, // output clock divider code
  input wire logic bus_master_en, // act as sync-bus master
  input wire logic local_sync, // locally made sync
  input wire logic local_gate, // locally made gate
  input wire logic vcxo_clk, // on-board oscillator (pin)
  input wire logic ext_clk, // front-panel clock (pin)
  input wire logic bus_clk_in, // sync-bus clock (pin)
  input wire logic bus_sync_in, // sync-bus sync (pin)
  input wire logic bus_gate_in, // sync-bus gate (pin)
  input wire logic pps_in, // pulse per second (pin)
  input wire logic [NSENS-1:0] sensor_alarm, // sensor alarms (pins)
  input wire logic [NCH-1:0] adc_overload, // converter overload (pins)
  input wire logic [NCH-1:0] adc_fifo_overrun, // capture fifo overrun
  input wire logic dac_fifo_empty, // output fifo empty
  input wire logic link_up, // host link trained
  input wire logic [7:0] lane_ok, // per-lane trained flags
  input wire logic user_led, // user application request
  input wire logic [15:0] clk_cnt_min, // least edges per window
  input wire logic [15:0] clk_cnt_max, // most edges per window
  output logic adc_clk_out, // input timing bus clock
  output logic adc_sync_out, // input timing bus sync
  output logic adc_gate_out, // input timing bus gate
  output logic dac_clk_out, // output timing bus clock
  output logic dac_sync_out, // output timing bus sync
  output logic dac_gate_out, // output timing bus gate
  output logic vcxo_lock_en, // phase-lock oscillator to reference
  output logic vcxo_ref_out, // reference clock to the lock loop
  output logic bus_clk_out, // sync-bus clock drive
  output logic bus_sync_out, // sync-bus sync drive
  output logic bus_gate_out, // sync-bus gate drive
  output logic bus_oe_n, // sync-bus drive enable, low drives
  output logic [3:0] link_width, // negotiated lane count
  output logic link_indicator, // link indicator
  output logic user_indicator, // user indicator
  output logic bus_master_indicator, // master indicator
  output logic pps_indicator, // pps indicator
  output logic thermal_alarm_indicator, // thermal indicator
  output logic clock_indicator, // clock indicator
  output logic data_enable, // data path may process samples
  output logic output_underrun_indicator, // output underrun indicator
  output logic [NCH-1:0] input_overload_indicator // per-input overload
);

  localparam int unsigned SW = 6 + NSENS + NCH;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a change is accepted only when stages two and three agree
  logic [SW-1:0] pins;
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;

  assign pins = {adc_overload, sensor_alarm, pps_in, bus_gate_in, bus_sync_in,
                 bus_clk_in, ext_clk, vcxo_clk};

  always_comb begin
    pin_next = pin_reg;
    for (int i = 0; i < SW; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        pin_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  logic vcxo_s, ext_s, bclk_s, bsync_s, bgate_s, pps_s;
  logic [NSENS-1:0] alarm_s;
  logic [NCH-1:0] ovl_s;
  assign {ovl_s, alarm_s, pps_s, bgate_s, bsync_s, bclk_s, ext_s, vcxo_s} = pin_reg;

  // ----------------------------------------------------------------
  // source selection and dividers
  // ----------------------------------------------------------------
  logic use_bus, src_now, sync_sel, gate_sel, src_edge;
  logic src_prev_reg;
  logic [3:0] div_cnt_reg [2], div_cnt_next [2];
  logic [1:0] div_out_reg, div_out_next;
  logic [2:0] code [2];

  always_comb begin
    // a master never takes its clock from the bus it drives
    use_bus = !bus_master_en || (clk_src_sel == TSI_SRC_BUS);
    if (!bus_master_en) begin
      src_now = bclk_s;
    end else begin
      case (clk_src_sel)
        TSI_SRC_EXT: src_now = vcxo_ref_en ? vcxo_s : ext_s;
        default: src_now = vcxo_s;
      endcase
    end
    sync_sel = bus_master_en ? local_sync : bsync_s;
    gate_sel = bus_master_en ? local_gate : bgate_s;
    src_edge = src_now && !src_prev_reg;
    code[0] = (adc_div_code > DIV_CODE_MAX) ? DIV_CODE_MAX : adc_div_code;
    code[1] = (dac_div_code > DIV_CODE_MAX) ? DIV_CODE_MAX : dac_div_code;
    for (int p = 0; p < 2; p++) begin
      div_cnt_next[p] = div_cnt_reg[p];
      div_out_next[p] = div_out_reg[p];
      if (code[p] == 3'h0) begin
        div_cnt_next[p] = 4'h0;
        div_out_next[p] = src_now; // straight through
      end else if (src_edge) begin
        if (div_cnt_reg[p] >= tsi_half(code[p])) begin
          div_cnt_next[p] = 4'h0;
          div_out_next[p] = !div_out_reg[p];
        end else begin
          div_cnt_next[p] = div_cnt_reg[p] + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_reg <= 1'b0;
      div_cnt_reg[0] <= 4'h0;
      div_cnt_reg[1] <= 4'h0;
      div_out_reg <= 2'h0;
    end else begin
      src_prev_reg <= src_now;
      div_cnt_reg[0] <= div_cnt_next[0];
      div_cnt_reg[1] <= div_cnt_next[1];
      div_out_reg <= div_out_next;
    end
  end

  // ----------------------------------------------------------------
  // clock presence, pps and link blink
  // ----------------------------------------------------------------
  logic [31:0] win_reg, win_next, pps_age_reg, pps_age_next;
  logic [31:0] pps_on_reg, pps_on_next, blink_reg, blink_next;
  logic [15:0] edges_reg, edges_next;
  logic clk_ok_reg, clk_ok_next, pps_ok_reg, pps_ok_next;
  logic pps_prev_reg, blink_on_reg, blink_on_next, pps_edge;

  always_comb begin
    win_next = win_reg + 32'h1;
    edges_next = edges_reg;
    clk_ok_next = clk_ok_reg;
    if (src_edge && edges_reg != 16'hffff) begin
      edges_next = edges_reg + 16'h1;
    end
    if (win_reg >= 32'(CLKDET_WIN_CYC - 1)) begin
      win_next = CNT_RST;
      edges_next = EDGE_CNT_RST;
      clk_ok_next = (edges_reg >= clk_cnt_min) && (edges_reg <= clk_cnt_max);
    end
    pps_edge = pps_s && !pps_prev_reg;
    pps_age_next = pps_age_reg + 32'h1;
    pps_ok_next = pps_ok_reg;
    pps_on_next = (pps_on_reg != CNT_RST) ? pps_on_reg - 32'h1 : CNT_RST;
    if (pps_edge) begin
      pps_age_next = CNT_RST;
      pps_ok_next = 1'b1;
      pps_on_next = 32'(PPS_ON);
    end else if (pps_age_reg >= 32'(PPS_TIMEOUT - 1)) begin
      // no pulse for too long: no longer valid
      pps_age_next = pps_age_reg;
      pps_ok_next = 1'b0;
    end
    blink_next = blink_reg + 32'h1;
    blink_on_next = blink_on_reg;
    if (!link_up) begin
      blink_next = CNT_RST;
      blink_on_next = 1'b0;
    end else if (blink_reg >= 32'(LINK_BLINK - 1)) begin
      blink_next = CNT_RST;
      blink_on_next = !blink_on_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_reg <= CNT_RST;
      edges_reg <= EDGE_CNT_RST;
      clk_ok_reg <= 1'b0;
      pps_prev_reg <= 1'b0;
      pps_age_reg <= CNT_RST;
      pps_ok_reg <= 1'b0;
      pps_on_reg <= CNT_RST;
      blink_reg <= CNT_RST;
      blink_on_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      edges_reg <= edges_next;
      clk_ok_reg <= clk_ok_next;
      pps_prev_reg <= pps_s;
      pps_age_reg <= pps_age_next;
      pps_ok_reg <= pps_ok_next;
      pps_on_reg <= pps_on_next;
      blink_reg <= blink_next;
      blink_on_reg <= blink_on_next;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [3:0] width_next;

  always_comb begin
    // widest group of 8, 4, 2 or 1 lanes from lane 0 that are all trained
    if (&lane_ok) begin
      width_next = 4'h8;
    end else if (&lane_ok[3:0]) begin
      width_next = 4'h4;
    end else if (&lane_ok[1:0]) begin
      width_next = 4'h2;
    end else if (lane_ok[0]) begin
      width_next = 4'h1;
    end else begin
      width_next = LINK_WIDTH_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_clk_out <= 1'b0;
      adc_sync_out <= 1'b0;
      adc_gate_out <= 1'b0;
      dac_clk_out <= 1'b0;
      dac_sync_out <= 1'b0;
      dac_gate_out <= 1'b0;
      vcxo_lock_en <= 1'b0;
      vcxo_ref_out <= 1'b0;
      bus_clk_out <= 1'b0;
      bus_sync_out <= 1'b0;
      bus_gate_out <= 1'b0;
      bus_oe_n <= 1'b1;
      link_width <= LINK_WIDTH_RST;
      link_indicator <= 1'b0;
      user_indicator <= 1'b0;
      bus_master_indicator <= 1'b0;
      pps_indicator <= 1'b0;
      thermal_alarm_indicator <= 1'b0;
      clock_indicator <= 1'b0;
      data_enable <= 1'b0;
      output_underrun_indicator <= 1'b0;
      input_overload_indicator <= '0;
    end else begin
      adc_clk_out <= div_out_reg[0];
      adc_sync_out <= sync_sel;
      adc_gate_out <= gate_sel;
      dac_clk_out <= div_out_reg[1];
      dac_sync_out <= sync_sel;
      dac_gate_out <= gate_sel;
      vcxo_lock_en <= bus_master_en && vcxo_ref_en && !use_bus;
      vcxo_ref_out <= bus_master_en && vcxo_ref_en && ext_s;
      bus_clk_out <= bus_master_en && src_now;
      bus_sync_out <= bus_master_en && local_sync;
      bus_gate_out <= bus_master_en && local_gate;
      bus_oe_n <= !bus_master_en;
      link_width <= link_up ? width_next : LINK_WIDTH_RST;
      link_indicator <= link_up && blink_on_reg;
      user_indicator <= user_led;
      bus_master_indicator <= bus_master_en;
      pps_indicator <= pps_ok_reg && (pps_on_reg != CNT_RST);
      thermal_alarm_indicator <= |alarm_s;
      clock_indicator <= clk_ok_reg;
      data_enable <= clk_ok_reg;
      output_underrun_indicator <= dac_fifo_empty;
      input_overload_indicator <= ovl_s | adc_fifo_overrun;
    end
  end

endmodule : tsi_timing_status

// ### testbench/tsi_timing_status_checker.sv
`timescale 1ns/100ps
module tsi_timing_status_checker #(
  parameter int unsigned NSENS = 4,
  parameter int unsigned NCH = 3
) (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, low active
  input wire logic user_led, // user request
  input wire logic bus_master_en, // master select
  input wire logic dac_fifo_empty, // output fifo empty
  input wire logic [NCH-1:0] adc_fifo_overrun, // capture overrun
  input wire logic link_up, // host link up
  input wire logic [NSENS-1:0] sensor_alarm, // sensor alarms
  input wire logic user_indicator, // lamp
  input wire logic bus_master_indicator, // lamp
  input wire logic bus_oe_n, // bus drive enable
  input wire logic output_underrun_indicator, // lamp
  input wire logic [NCH-1:0] input_overload_indicator, // lamps
  input wire logic [3:0] link_width, // lane count
  input wire logic link_indicator, // lamp
  input wire logic thermal_alarm_indicator, // lamp
  input wire logic clock_indicator, // lamp
  input wire logic data_enable // data gate
);
  localparam int LB_SPAN = 12;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  logic ready;
  // ------------------------------------------------------------
  // reset age: outputs lag the two-flop release, skip first edges
  // ------------------------------------------------------------
  always_comb begin
    age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      age_reg <= 3'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  assign ready = (age_reg >= 3'h4);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence alarm_held;
    (ready && (|sensor_alarm)) [*8];
  endsequence
  a_user_lamp: assert property (ready |=> user_indicator == $past(user_led))
    else $error("user indicator does not follow request");
  a_master_lamp: assert property (ready |=> bus_master_indicator == $past(bus_master_en))
    else $error("master indicator wrong");
  a_bus_drive: assert property (ready |=> bus_oe_n == !$past(bus_master_en))
    else $error("bus drive enable wrong");
  a_underrun_lamp: assert property (ready |=> output_underrun_indicator == $past(dac_fifo_empty))
    else $error("underrun indicator wrong");
  a_overrun_lamp: assert property (ready |=>
    (input_overload_indicator & $past(adc_fifo_overrun)) == $past(adc_fifo_overrun))
    else $error("overrun not shown on overload indicator");
  a_width_down: assert property (ready && !link_up |=> link_width == 4'h0)
    else $error("lane count not zero with link down");
  a_link_blink: assert property (ready && link_up |->
    ##[1:LB_SPAN] ($changed(link_indicator) || !link_up))
    else $error("link indicator not blinking");
  a_clock_gate: assert property (ready |-> clock_indicator == data_enable)
    else $error("data enable differs from clock indicator");
  // the verdict is only refreshed once per counting window, never twice in a row
  a_clock_steady: assert property (ready && $changed(clock_indicator) |=>
    $stable(clock_indicator) [*8])
    else $error("clock indicator changed inside a counting window");
  a_thermal_on: assert property (alarm_held |-> thermal_alarm_indicator)
    else $error("thermal indicator dark during alarm");
endmodule : tsi_timing_status_checker
bind tsi_timing_status tsi_timing_status_checker #(.NSENS(NSENS), .NCH(NCH)) u_chk (.*);

// ### testbench/tsi_sync_peer.sv
`timescale 1ns/100ps
module tsi_sync_peer #(
  parameter int HALF_NS = 36
) (
  input wire logic drive_en, // peer owns the bus
  input wire logic sync_lvl, // sync to drive
  input wire logic gate_lvl, // gate to drive
  output logic bus_clk, // bus clock
  output logic bus_sync, // bus sync
  output logic bus_gate // bus gate
);
  logic run_clk = 1'b0;
  // ------------------------------------------------------------
  // peer master drive
  // ------------------------------------------------------------
  // 1 ns offset keeps every toggle off the sampling edge of the block
  initial begin
    #1;
    forever #(HALF_NS) run_clk = ~run_clk;
  end
  // released lines show the inverse, so a stale level is never mistaken for a drive
  assign bus_clk = drive_en ? run_clk : ~run_clk;
  assign bus_sync = drive_en ? sync_lvl : ~sync_lvl;
  assign bus_gate = drive_en ? gate_lvl : ~gate_lvl;
endmodule : tsi_sync_peer

// ### testbench/tb_timing_sync_and_status_indicators.sv
`timescale 1ns/100ps
module tb_timing_sync_and_status_indicators;
  import tsi_pkg::*;
  logic sys_clk, nrst, vcxo_ref_en, bus_master_en, local_sync, local_gate, pps_in;
  logic vcxo_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_run, peer_sync, peer_gate, dac_fifo_empty, link_up, user_led;
  logic [1:0] clk_src_sel;
  logic [2:0] adc_div_code, dac_div_code, adc_overload, adc_fifo_overrun;
  logic [3:0] sensor_alarm;
  logic [7:0] lane_ok;
  logic [15:0] clk_cnt_min, clk_cnt_max;
  wire bus_clk_in, bus_sync_in, bus_gate_in;
  logic adc_clk_out, adc_sync_out, adc_gate_out, dac_clk_out, dac_sync_out, dac_gate_out;
  logic vcxo_lock_en, vcxo_ref_out, bus_clk_out, bus_sync_out, bus_gate_out, bus_oe_n;
  logic [3:0] link_width;
  logic link_indicator, user_indicator, bus_master_indicator, pps_indicator;
  logic thermal_alarm_indicator, clock_indicator, data_enable, output_underrun_indicator;
  logic [2:0] input_overload_indicator;
  int mismatches = 0;
  int num_checks = 0;
  int adc_n, dac_n, lnk_n, ref_n, bclk_n;
  logic [7:0] lanes [6] = '{8'hff, 8'h7f, 8'h0f, 8'h03, 8'h01, 8'h0d};
  logic [3:0] widths [6] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h1, 4'h1};
  logic [3:0] src_cfg [5] = '{4'h8, 4'ha, 4'h4, 4'hb, 4'hc};
  int src_exp [5] = '{129, 180, 100, 129, 129};
  tsi_timing_status #(.LINK_BLINK(8), .PPS_TIMEOUT(50), .PPS_ON(5)) uut (.*);
  tsi_sync_peer u_peer (.drive_en(!bus_master_en), .sync_lvl(peer_sync), .gate_lvl(peer_gate),
    .bus_clk(bus_clk_in), .bus_sync(bus_sync_in), .bus_gate(bus_gate_in));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // pin clocks start 1 ns late so no toggle lands on a sampling edge
  initial begin
    #1;
    fork
      forever #28 vcxo_clk = ~vcxo_clk;
      forever #20 ext_clk = ext_run & ~ext_clk;
    join
  end
  always @(posedge vcxo_ref_out) ref_n++;
  always @(posedge bus_clk_out) bclk_n++;
  always @(posedge adc_clk_out) adc_n++;
  always @(posedge dac_clk_out) dac_n++;
  always @(posedge link_indicator) lnk_n++;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // two edges of slack: synchronisers shift the counting window
  task automatic chk_near(input string what, input int exp, input int got);
    num_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_near
  task automatic set_cfg(input logic m, input logic [1:0] s, input logic r);
    bus_master_en = m;
    clk_src_sel = s;
    vcxo_ref_en = r;
    tick(10);
  endtask : set_cfg
  task automatic measure(input int n);
    adc_n = 0;
    dac_n = 0;
    ref_n = 0;
    bclk_n = 0;
    tick(n);
  endtask : measure
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  initial begin
    {nrst, vcxo_ref_en, local_sync, local_gate, pps_in, peer_sync, peer_gate} = '0;
    {dac_fifo_empty, link_up, user_led, clk_src_sel, adc_overload, adc_fifo_overrun} = '0;
    {adc_div_code, dac_div_code, sensor_alarm, lane_ok} = '0;
    ext_run = 1'b1;
    bus_master_en = 1'b1; // lone module starts as master
    clk_cnt_min = 16'h0096;
    clk_cnt_max = 16'h0104;
    tick(16);
    nrst = 1'b1;
    tick(4);
    for (int i = 0; i < 2; i++) begin
      logic v;
      v = (i == 0);
      user_led = v;
      dac_fifo_empty = v;
      adc_fifo_overrun = {v, 1'b0, v};
      tick(2);
      chk("user", v, user_indicator);
      chk("underrun", v, output_underrun_indicator);
      chk("overload", {v, 1'b0, v}, input_overload_indicator);
    end
    adc_overload = 3'h2;
    tick(8);
    chk("pin_ovl", 3'h2, input_overload_indicator);
    adc_overload = 3'h0;
    for (int i = 0; i < 4; i++) begin
      sensor_alarm = 4'h1 << i;
      tick(8);
      chk("thermal", 1'b1, thermal_alarm_indicator);
      sensor_alarm = 4'h0;
      tick(8);
      chk("thermal", 1'b0, thermal_alarm_indicator);
    end
    link_up = 1'b1;
    for (int i = 0; i < 6; i++) begin
      lane_ok = lanes[i];
      tick(2);
      chk("width", widths[i], link_width);
    end
    lnk_n = 0;
    tick(80);
    chk_near("blink", 5, lnk_n);
    link_up = 1'b0;
    lane_ok = 8'hff;
    tick(2);
    chk("width", 4'h0, link_width);
    local_sync = 1'b1;
    peer_gate = 1'b1;
    set_cfg(1'b1, 2'h1, 1'b0);
    chk("master", 1'b1, bus_master_indicator);
    chk("oe_n", 1'b0, bus_oe_n);
    chk("bus_out", 2'h2, {bus_sync_out, bus_gate_out});
    chk("timing", 4'ha, {adc_sync_out, adc_gate_out, dac_sync_out, dac_gate_out});
    set_cfg(1'b0, 2'h1, 1'b0);
    chk("master", 1'b0, bus_master_indicator);
    chk("oe_n", 1'b1, bus_oe_n);
    chk("bus_out", 2'h0, {bus_sync_out, bus_gate_out});
    chk("timing", 4'h5, {adc_sync_out, adc_gate_out, dac_sync_out, dac_gate_out});
    for (int i = 0; i < 5; i++) begin
      set_cfg(src_cfg[i][3], src_cfg[i][2:1], src_cfg[i][0]);
      measure(900);
      chk_near("source", src_exp[i], adc_n);
      chk("lock", i == 3, vcxo_lock_en);
      chk_near("ref", (i == 3) ? 180 : 0, ref_n);
      chk_near("bus_clk", src_cfg[i][3] ? src_exp[i] : 0, bclk_n);
    end
    set_cfg(1'b1, 2'h1, 1'b0);
    for (int k = 0; k < 5; k++) begin
      adc_div_code = 3'(k);
      dac_div_code = 3'(4 - k);
      tick(4);
      measure(900);
      chk_near("adc_div", 180 >> k, adc_n);
      chk_near("dac_div", 180 >> (4 - k), dac_n);
    end
    tick(2200);
    chk("clk_ok", 2'h3, {clock_indicator, data_enable});
    clk_cnt_min = 16'h012c;
    tick(2200);
    chk("clk_band", 2'h0, {clock_indicator, data_enable});
    clk_cnt_min = 16'h0096;
    ext_run = 1'b0;
    tick(2200);
    chk("clk_gone", 2'h0, {clock_indicator, data_enable});
    ext_run = 1'b1;
    repeat (3) begin
      pps_in = 1'b1;
      tick(3);
      pps_in = 1'b0;
      tick(4);
      chk("pps_on", 1'b1, pps_indicator);
      tick(10);
      chk("pps_off", 1'b0, pps_indicator);
      tick(3);
    end
    final_report();
  end
endmodule : tb_timing_sync_and_status_indicators
